// File: fmc_pkg.sv
// Package for the fan monitor configuration register bank.
// Assumes a 40 MHz sys_clk and register indices mapped as byte address = 4 * index.
`default_nettype none

package fmc_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INT_STATUS2 = 8'h42;
  localparam logic [7:0] IDX_LOCK_IO = 8'h60;
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h79;
  localparam logic [7:0] IDX_TIMER_LIMIT = 8'h7A;
  localparam logic [7:0] IDX_TACH_COUNT = 8'h7B;
  localparam logic [7:0] IDX_RANGE_IO = 8'h7C;
  localparam logic [7:0] IDX_PIN_OT = 8'h7D;

  // Reset values
  localparam logic [7:0] RST_TIMER_LIMIT = 8'h00;
  localparam logic [7:0] RST_TACH_COUNT = 8'h55;
  localparam logic [7:0] RST_RANGE_IO = 8'h01;
  localparam logic [7:0] RST_PIN_OT = 8'h00;

  // Writable masks; reserved bits read zero
  localparam logic [7:0] MASK_RANGE_IO = 8'hEF;
  localparam logic [7:0] MASK_PIN_OT = 8'h2F;

  // Field positions
  localparam int POS_FAULT_FLAG = 5;
  localparam int POS_SIGNED = 0;
  localparam int POS_OFFSET_RANGE = 1;
  localparam int POS_IO_DIR = 2;
  localparam int POS_IO_POL = 3;
  localparam int POS_LIMIT_OFF0 = 5;
  localparam int POS_OT_OFF = 2;
  localparam int POS_LEVEL_SEL = 3;
  localparam int POS_BYPASS = 5;
  localparam int POS_LOCK = 0;
  localparam int POS_IO_VALUE = 1;
  localparam int POS_IO_PIN = 2;

  // Limit codes that switch a channel off in each encoding
  localparam logic [7:0] LIMIT_OFF_BIASED = 8'h00;
  localparam logic [7:0] LIMIT_OFF_SIGNED = 8'h80;

  // Timer step: 22.76 ms at a 25 ns clock
  localparam longint CLK_PERIOD_PS = 25000;
  localparam longint OT_STEP_PS = 64'd22760000000;
  localparam int OT_STEP_CYCLES = int'(OT_STEP_PS / CLK_PERIOD_PS);
  localparam logic [7:0] TIMER_FIRST_STEP = 8'h02;

  typedef enum logic [1:0]
  {
    PIN_TACH,
    PIN_OVERTEMP,
    PIN_ALERT,
    PIN_GENERAL_IO
  } fmc_pin_fn_type;

  typedef struct packed
  {
    logic out;
    logic oe;
  } fmc_pin_drive_type;

  typedef struct packed
  {
    logic force_full;
    logic force_max;
  } fmc_fan_cmd_type;

endpackage

`default_nettype wire

// File: fmc_config_regs.sv
// Configuration, limit and overtemperature timer registers of the fan monitor.
// Assumes an APB master on sys_clk and an asynchronous multi-purpose pin.

`timescale 1ns/1ps
`default_nettype none

module fmc_config_regs #(
  parameter int STEP_CYCLES = fmc_pkg::OT_STEP_CYCLES,
  parameter int CHANNELS = 3,
  parameter int FANS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Multi-purpose pin
  input wire logic multi_pin_in,
  output fmc_pkg::fmc_pin_drive_type multi_pin_drive,
  output logic fourth_tach_input,
  // Temperature and alert path
  input wire logic [CHANNELS-1:0] temp_over_limit,
  input wire logic [CHANNELS*8-1:0] overtemp_limit_codes,
  input wire logic alert_request,
  output logic signed_range_sel,
  output logic offset_range_sel,
  output logic core_volt_attenuator_bypass,
  output logic [FANS*3-1:0] tach_pulse_counts,
  output fmc_pkg::fmc_fan_cmd_type fan_cmd,
  output logic fourth_fan_fault_flag
);

  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  // Register storage
  logic [7:0] time_limit_ff;
  logic [7:0] tach_sel_ff;
  logic [7:0] range_io_ff;
  logic [7:0] pin_ot_ff;
  logic lock_ff;
  logic io_value_ff;
  logic fault_flag_ff;
  logic assert_flag_ff;
  logic [7:0] time_count_ff;
  logic [PRE_W-1:0] prescale_ff;
  logic ot_seen_ff;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic sig_range_ff;
  logic off_range_ff;
  logic bypass_ff;
  logic [FANS*3-1:0] tach_counts_ff;
  fmc_pkg::fmc_pin_drive_type pin_drive_ff;
  fmc_pkg::fmc_fan_cmd_type fan_cmd_ff;
  logic tach_in_ff;

  // Bus decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic addr_aligned;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] nxt_rdata;

  // Derived controls
  fmc_pkg::fmc_pin_fn_type pin_fn;
  logic ot_asserted;
  logic ot_rise;
  logic step_tick;
  logic [7:0] nxt_time_count;
  logic fault_set;
  logic [CHANNELS-1:0] channel_exceeded;
  logic any_exceeded;
  logic [7:0] limit_off_code;
  logic [7:0] timer_status;

  // Zero-wait slave: data is staged in setup so it comes from a flop
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign addr_aligned = (paddr[1:0] == 2'b00);
  assign idx = paddr[9:2];
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  always_comb
  begin
    mapped = 1'b1;
    case (idx)
      fmc_pkg::IDX_INT_STATUS2,
      fmc_pkg::IDX_LOCK_IO,
      fmc_pkg::IDX_TIMER_STATUS,
      fmc_pkg::IDX_TIMER_LIMIT,
      fmc_pkg::IDX_TACH_COUNT,
      fmc_pkg::IDX_RANGE_IO,
      fmc_pkg::IDX_PIN_OT: mapped = addr_aligned && (paddr[fmc_pkg::ADDR_W-1:10] == '0);
      default: mapped = 1'b0;
    endcase
  end

  // Status bit 0 is the assertion flag until the count reaches two steps
  always_comb
  begin
    timer_status = time_count_ff;
    if (time_count_ff < fmc_pkg::TIMER_FIRST_STEP)
    begin
      timer_status = {7'h00, assert_flag_ff};
    end
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    case (idx)
      fmc_pkg::IDX_INT_STATUS2: nxt_rdata[fmc_pkg::POS_FAULT_FLAG] = fault_flag_ff;
      fmc_pkg::IDX_LOCK_IO:
      begin
        nxt_rdata[fmc_pkg::POS_LOCK] = lock_ff;
        nxt_rdata[fmc_pkg::POS_IO_VALUE] = io_value_ff;
        nxt_rdata[fmc_pkg::POS_IO_PIN] = pin_sync_ff;
      end
      fmc_pkg::IDX_TIMER_STATUS: nxt_rdata = timer_status;
      fmc_pkg::IDX_TIMER_LIMIT: nxt_rdata = time_limit_ff;
      fmc_pkg::IDX_TACH_COUNT: nxt_rdata = tach_sel_ff;
      fmc_pkg::IDX_RANGE_IO: nxt_rdata = range_io_ff;
      fmc_pkg::IDX_PIN_OT: nxt_rdata = pin_ot_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= (mapped && !pwrite) ? {24'h00_0000, nxt_rdata} : 32'h0000_0000;
      pslverr_ff <= !mapped;
    end
  end

  // Time limit, cleared at power-on
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      time_limit_ff <= fmc_pkg::RST_TIMER_LIMIT;
    end
    else if (wr_done && mapped && idx == fmc_pkg::IDX_TIMER_LIMIT)
    begin
      time_limit_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tach_sel_ff <= fmc_pkg::RST_TACH_COUNT;
    end
    else if (wr_done && mapped && idx == fmc_pkg::IDX_TACH_COUNT)
    begin
      tach_sel_ff <= pwdata[7:0];
    end
  end

  // Configuration registers refuse writes silently once locked
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      range_io_ff <= fmc_pkg::RST_RANGE_IO;
      pin_ot_ff <= fmc_pkg::RST_PIN_OT;
    end
    else if (wr_done && mapped && !lock_ff)
    begin
      if (idx == fmc_pkg::IDX_RANGE_IO)
      begin
        range_io_ff <= pwdata[7:0] & fmc_pkg::MASK_RANGE_IO;
      end
      if (idx == fmc_pkg::IDX_PIN_OT)
      begin
        pin_ot_ff <= pwdata[7:0] & fmc_pkg::MASK_PIN_OT;
      end
    end
  end

  // Lock only releases with reset, so it cannot be undone by software
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_ff <= 1'b0;
      io_value_ff <= 1'b0;
    end
    else if (wr_done && mapped && idx == fmc_pkg::IDX_LOCK_IO)
    begin
      lock_ff <= lock_ff | pwdata[fmc_pkg::POS_LOCK];
      io_value_ff <= pwdata[fmc_pkg::POS_IO_VALUE];
    end
  end

  // Pin synchroniser; only the second stage is used
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= multi_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign pin_fn = fmc_pkg::fmc_pin_fn_type'(pin_ot_ff[1:0]);
  // Overtemp input is active low and only heard in the overtemp pin role
  assign ot_asserted = (pin_fn == fmc_pkg::PIN_OVERTEMP) && !pin_sync_ff;
  assign ot_rise = ot_asserted && !ot_seen_ff;
  assign step_tick = ot_asserted && (prescale_ff == PRE_LAST);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_seen_ff <= 1'b0;
    end
    else
    begin
      ot_seen_ff <= ot_asserted;
    end
  end

  // Prescaler restarts on each assertion and idles while deasserted
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_ff <= '0;
    end
    else if (!ot_asserted || step_tick)
    begin
      prescale_ff <= '0;
    end
    else
    begin
      prescale_ff <= prescale_ff + 1'b1;
    end
  end

  // Count saturates rather than wrapping so long assertions stay visible
  always_comb
  begin
    nxt_time_count = time_count_ff;
    if (rd_done && mapped && idx == fmc_pkg::IDX_TIMER_STATUS)
    begin
      nxt_time_count = 8'h00;
    end
    if (step_tick && time_count_ff != 8'hFF)
    begin
      nxt_time_count = (rd_done && mapped && idx == fmc_pkg::IDX_TIMER_STATUS) ? 8'h01
        : time_count_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      time_count_ff <= 8'h00;
    end
    else
    begin
      time_count_ff <= nxt_time_count;
    end
  end

  // Assertion flag: a new assertion wins over a clearing read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      assert_flag_ff <= 1'b0;
    end
    else if (ot_rise)
    begin
      assert_flag_ff <= 1'b1;
    end
    else if (rd_done && mapped && idx == fmc_pkg::IDX_TIMER_STATUS)
    begin
      assert_flag_ff <= 1'b0;
    end
  end

  // Compared against the count after each step
  assign fault_set = (step_tick && (time_count_ff + 9'h001) > {1'b0, time_limit_ff})
    || (ot_rise && time_limit_ff == 8'h00);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_flag_ff <= 1'b0;
    end
    else if (fault_set)
    begin
      fault_flag_ff <= 1'b1;
    end
    else if (rd_done && mapped && idx == fmc_pkg::IDX_INT_STATUS2)
    begin
      fault_flag_ff <= 1'b0;
    end
  end

  // Disabled-limit code follows the live encoding, so a switch applies at once
  assign limit_off_code = range_io_ff[fmc_pkg::POS_SIGNED] ? fmc_pkg::LIMIT_OFF_SIGNED
    : fmc_pkg::LIMIT_OFF_BIASED;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
      assign channel_exceeded[ch] = temp_over_limit[ch]
        && !range_io_ff[fmc_pkg::POS_LIMIT_OFF0 + ch]
        && (overtemp_limit_codes[ch*8 +: 8] != limit_off_code);
    end
  endgenerate

  assign any_exceeded = |channel_exceeded;

  // Fan response does not depend on whether the pin may drive
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_cmd_ff <= '0;
    end
    else
    begin
      fan_cmd_ff.force_full <= any_exceeded && !pin_ot_ff[fmc_pkg::POS_LEVEL_SEL];
      fan_cmd_ff.force_max <= any_exceeded && pin_ot_ff[fmc_pkg::POS_LEVEL_SEL];
    end
  end

  // Pin drive per role; overtemp and alert are open-drain low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_drive_ff <= '0;
    end
    else
    begin
      pin_drive_ff <= '0;
      unique case (pin_fn)
        fmc_pkg::PIN_TACH: pin_drive_ff <= '0;
        fmc_pkg::PIN_OVERTEMP:
        begin
          pin_drive_ff.oe <= any_exceeded && !pin_ot_ff[fmc_pkg::POS_OT_OFF];
        end
        fmc_pkg::PIN_ALERT: pin_drive_ff.oe <= alert_request;
        fmc_pkg::PIN_GENERAL_IO:
        begin
          pin_drive_ff.oe <= range_io_ff[fmc_pkg::POS_IO_DIR];
          // Polarity clear means an asserted value drives low
          pin_drive_ff.out <= io_value_ff ~^ range_io_ff[fmc_pkg::POS_IO_POL];
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tach_in_ff <= 1'b1;
    end
    else
    begin
      tach_in_ff <= (pin_fn == fmc_pkg::PIN_TACH) ? pin_sync_ff : 1'b1;
    end
  end

  // Per-fan pulse count is the selector plus one
  genvar fn;
  generate
    for (fn = 0; fn < FANS; fn++)
    begin : g_fan
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tach_counts_ff[fn*3 +: 3] <= 3'h2;
        end
        else
        begin
          tach_counts_ff[fn*3 +: 3] <= {1'b0, tach_sel_ff[fn*2 +: 2]} + 3'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sig_range_ff <= 1'b1;
      off_range_ff <= 1'b0;
      bypass_ff <= 1'b0;
    end
    else
    begin
      sig_range_ff <= range_io_ff[fmc_pkg::POS_SIGNED];
      off_range_ff <= range_io_ff[fmc_pkg::POS_OFFSET_RANGE];
      bypass_ff <= pin_ot_ff[fmc_pkg::POS_BYPASS];
    end
  end

  assign signed_range_sel = sig_range_ff;
  assign offset_range_sel = off_range_ff;
  assign core_volt_attenuator_bypass = bypass_ff;
  assign tach_pulse_counts = tach_counts_ff;
  assign fan_cmd = fan_cmd_ff;
  assign multi_pin_drive = pin_drive_ff;
  assign fourth_tach_input = tach_in_ff;
  assign fourth_fan_fault_flag = fault_flag_ff;

endmodule // fmc_config_regs

`default_nettype wire

// File: fmc_config_regs_asserts.sv
// Concurrent checks on the ports of the fan monitor register bank.
// Assumes binding onto fmc_config_regs, one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fmc_config_regs_asserts #(
  parameter int CHANNELS = 3,
  parameter int FANS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] temp_over_limit,
  input wire logic signed_range_sel,
  input wire logic offset_range_sel,
  input wire logic core_volt_attenuator_bypass,
  input wire logic [FANS*3-1:0] tach_pulse_counts,
  input wire fmc_pkg::fmc_fan_cmd_type fan_cmd,
  input wire logic fourth_fan_fault_flag
);
  logic lock_ff;
  logic [7:0] wd_ff;
  logic wr_hit;
  assign wr_hit = psel && penable && pwrite;

  function automatic logic mapped(logic [11:0] a);
    return a inside {12'h108, 12'h180, 12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0, 12'h1F4};
  endfunction

  function automatic logic [11:0] cnt(logic [7:0] d);
    for (int i = 0; i < 4; i++)
      cnt[3*i+:3] = {1'b0, d[2*i+:2]} + 3'h1;
  endfunction

  // Lock is sticky until reset, so a shadow copy is enough
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_ff <= 1'b0;
    else if (wr_hit && paddr == 12'h180 && pwdata[0])
      lock_ff <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_ff <= 8'h00;
    else if (wr_hit)
      wd_ff <= pwdata[7:0];
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_tach_follow: assert property (wr_hit && paddr == 12'h1EC |->
    ##[1:2] tach_pulse_counts == cnt(wd_ff))
    else $error("tach counts do not follow selector");
  chk_range_copy: assert property (wr_hit && paddr == 12'h1F0 && !lock_ff |->
    ##[1:2] {signed_range_sel, offset_range_sel} == {wd_ff[0], wd_ff[1]})
    else $error("range outputs do not follow write");
  chk_bypass_copy: assert property (wr_hit && paddr == 12'h1F4 && !lock_ff |->
    ##[1:2] core_volt_attenuator_bypass == wd_ff[5])
    else $error("bypass output does not follow write");
  chk_lock_holds: assert property (wr_hit && paddr inside {12'h1F0, 12'h1F4} && lock_ff |=>
    $stable({signed_range_sel, offset_range_sel, core_volt_attenuator_bypass}) [*2])
    else $error("locked write changed configuration");
  chk_unmapped_err: assert property (psel && !penable && !mapped(paddr) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && !penable && mapped(paddr) |=> !pslverr && prdata[31:8] == 24'h0)
    else $error("mapped access refused or wide data");
  chk_read_holds: assert property (psel && penable |=> $stable({prdata, pslverr}))
    else $error("read data moved after access");
  chk_fault_sticky: assert property ($fell(fourth_fan_fault_flag) |->
    $past(psel && penable && !pwrite && paddr == 12'h108))
    else $error("fault flag cleared without status read");
  chk_fan_cause: assert property (fan_cmd.force_full || fan_cmd.force_max |->
    $past(|temp_over_limit) && !(fan_cmd.force_full && fan_cmd.force_max))
    else $error("fan command without exceeded limit");
endmodule // fmc_config_regs_asserts

bind fmc_config_regs fmc_config_regs_asserts #(.CHANNELS(CHANNELS), .FANS(FANS)) fmc_config_regs_asserts_i (
  .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .temp_over_limit,
  .signed_range_sel, .offset_range_sel, .core_volt_attenuator_bypass, .tach_pulse_counts, .fan_cmd,
  .fourth_fan_fault_flag
);

`default_nettype wire

// File: fmc_pin_partner.sv
// Board model of the shared multi-purpose pin with a pull-up.
// Assumes an external source that may only pull the pin low.
`timescale 1ns/1ps
`default_nettype none

module fmc_pin_partner (
  input wire logic ext_pull_low,
  input wire fmc_pkg::fmc_pin_drive_type drive,
  output logic pin_level
);
  // Either party pulling low wins; released pin goes to the pull-up
  assign pin_level = !(ext_pull_low || (drive.oe && !drive.out));
endmodule // fmc_pin_partner

`default_nettype wire

// File: tb_fmc_config_regs.sv
// Self-checking bench for the fan monitor register bank.
// Assumes APB access, a 40 MHz clock and a pulled-up multi-purpose pin.
`timescale 1ns/1ps
`default_nettype none

module tb_fmc_config_regs;
  localparam int STEP = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] temp_over_limit = 3'h0;
  logic [23:0] overtemp_limit_codes = 24'h0;
  logic alert_request = 1'b0;
  logic ext_low = 1'b0;
  logic pin_level, pready, pslverr, fourth_tach_input, signed_range_sel, offset_range_sel;
  logic core_volt_attenuator_bypass, fourth_fan_fault_flag, er;
  logic [31:0] prdata, rd;
  logic [11:0] tach_pulse_counts;
  fmc_pkg::fmc_pin_drive_type multi_pin_drive;
  fmc_pkg::fmc_fan_cmd_type fan_cmd;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] cfg [4] = '{8'h01, 8'h00, 8'h00, 8'h21};
  logic [7:0] code [4] = '{8'h80, 8'h80, 8'h00, 8'h50};
  logic full [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  always #12.5 sys_clk = ~sys_clk;

  fmc_config_regs #(.STEP_CYCLES(STEP)) fmc_config_regs_i (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .multi_pin_in(pin_level), .multi_pin_drive, .fourth_tach_input, .temp_over_limit, .overtemp_limit_codes,
    .alert_request, .signed_range_sel, .offset_range_sel, .core_volt_attenuator_bypass, .tach_pulse_counts,
    .fan_cmd, .fourth_fan_fault_flag
  );

  fmc_pin_partner fmc_pin_partner_i (.ext_pull_low(ext_low), .drive(multi_pin_drive), .pin_level);

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic bit_expect(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t port %b expected %b", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd_expect(input logic [11:0] a, input logic [7:0] exp, input logic exp_err);
    xfer(a, 1'b0, 8'h00);
    cmp_count++;
    if ({er, rd} !== {exp_err, 24'h0, exp})
    begin
      n_errors++;
      $display("MISMATCH %0t read %h err %b expected %h", $time, rd, er, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial
  begin
    idle(12);
    rst_n <= 1'b1;
    idle(2);
    bit_expect(tach_pulse_counts === 12'h492, 1'b1);
    bit_expect(signed_range_sel, 1'b1);
    rd_expect(12'h1E8, 8'h00, 1'b0);
    rd_expect(12'h1EC, 8'h55, 1'b0);
    rd_expect(12'h1F0, 8'h01, 1'b0);
    rd_expect(12'h1F4, 8'h00, 1'b0);
    rd_expect(12'h1FC, 8'h00, 1'b1);
    ext_low <= 1'b1;
    idle(4);
    bit_expect(fourth_tach_input, 1'b0);
    ext_low <= 1'b0;
    idle(4);
    bit_expect(fourth_tach_input, 1'b1);
    wr(12'h1EC, 8'hE4);
    idle(3);
    bit_expect(tach_pulse_counts === 12'h8D1, 1'b1);
    wr(12'h1F0, 8'hFF);
    rd_expect(12'h1F0, 8'hEF, 1'b0);
    bit_expect(offset_range_sel, 1'b1);
    wr(12'h1F4, 8'hFF);
    rd_expect(12'h1F4, 8'h2F, 1'b0);
    bit_expect(core_volt_attenuator_bypass, 1'b1);
    wr(12'h1F4, 8'h00);
    temp_over_limit <= 3'b001;
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h1F0, cfg[i]);
      overtemp_limit_codes <= {16'h0, code[i]};
      idle(3);
      bit_expect(fan_cmd.force_full, full[i]);
    end
    wr(12'h1F0, 8'h01);
    overtemp_limit_codes <= 24'h000050;
    idle(3);
    bit_expect(fan_cmd.force_full, 1'b1);
    wr(12'h1F4, 8'h08);
    idle(3);
    bit_expect(fan_cmd.force_max && !fan_cmd.force_full, 1'b1);
    wr(12'h1F4, 8'h01);
    idle(3);
    bit_expect(multi_pin_drive.oe && !multi_pin_drive.out, 1'b1);
    wr(12'h1F4, 8'h05);
    idle(3);
    bit_expect(multi_pin_drive.oe, 1'b0);
    temp_over_limit <= 3'b000;
    // Own drive of the pin counted as an assertion with a zero limit
    rd_expect(12'h108, 8'h20, 1'b0);
    rd_expect(12'h108, 8'h00, 1'b0);
    xfer(12'h1E4, 1'b0, 8'h00);
    ext_low <= 1'b1;
    idle(4);
    ext_low <= 1'b0;
    idle(2);
    bit_expect(fourth_fan_fault_flag, 1'b1);
    rd_expect(12'h1E4, 8'h01, 1'b0);
    rd_expect(12'h1E4, 8'h00, 1'b0);
    wr(12'h1E8, 8'h03);
    xfer(12'h108, 1'b0, 8'h00);
    ext_low <= 1'b1;
    idle(10);
    ext_low <= 1'b0;
    idle(3);
    bit_expect(fourth_fan_fault_flag, 1'b0);
    ext_low <= 1'b1;
    idle(30);
    ext_low <= 1'b0;
    idle(3);
    bit_expect(fourth_fan_fault_flag, 1'b1);
    // Two plus seven steps of four cycles each have been counted by now
    rd_expect(12'h1E4, 8'h09, 1'b0);
    wr(12'h180, 8'h02);
    wr(12'h1F0, 8'h0D);
    wr(12'h1F4, 8'h03);
    idle(3);
    bit_expect(multi_pin_drive.oe && multi_pin_drive.out, 1'b1);
    wr(12'h1F0, 8'h05);
    idle(3);
    bit_expect(multi_pin_drive.out, 1'b0);
    wr(12'h1F0, 8'h01);
    idle(3);
    bit_expect(multi_pin_drive.oe, 1'b0);
    wr(12'h1F4, 8'h02);
    alert_request <= 1'b1;
    idle(3);
    bit_expect(multi_pin_drive.oe && !multi_pin_drive.out, 1'b1);
    alert_request <= 1'b0;
    wr(12'h180, 8'h01);
    wr(12'h1F0, 8'h00);
    wr(12'h1F4, 8'h00);
    rd_expect(12'h1F0, 8'h01, 1'b0);
    rd_expect(12'h1F4, 8'h02, 1'b0);
    bit_expect(signed_range_sel, 1'b1);
    // Lock set, output value cleared, released pin reads high
    rd_expect(12'h180, 8'h05, 1'b0);
    conclude();
  end
endmodule // tb_fmc_config_regs

`default_nettype wire
